// ### fsm_readback.sv
module fsm_readback
  import fsm_pkg::*;
#(
  parameter int GPIN_N = 4
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic [GPIN_N-1:0] gpin_level,
  input  wire logic [GPIN_N-1:0] gpin_is_input,
  input  wire logic              sample_clk,
  input  wire logic              cs_bit,
  input  wire logic              cs_bit_valid,
  input  wire logic              cs_block_start,
  input  wire logic              flag_read_ack,
  input  wire logic              scb_clk,
  input  wire logic              scb_ce,
  input  wire logic              scb_di,
  output logic                   scb_do,
  output logic                   scb_do_oe,
  output logic                   rate_update_flag,
  output logic                   chstat_renewed_flag
);

  // ==========================================================================
  // Reset release and pin synchronisers.
  logic [1:0]        rst_sync_ff;
  logic              rst_n;
  logic [GPIN_N-1:0] gp_meta_ff;
  logic [GPIN_N-1:0] gp_ff;
  logic [3:0]        pin_meta_ff;
  logic [3:0]        pin_ff;
  logic [3:0]        pin_prev_ff;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // Bit order of the pin group: sample clock, bus clock, enable, data.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gp_meta_ff  <= '0;
      gp_ff       <= '0;
      pin_meta_ff <= 4'h0;
      pin_ff      <= 4'h0;
      pin_prev_ff <= 4'h0;
    end else begin
      gp_meta_ff  <= gpin_level;
      gp_ff       <= gp_meta_ff;
      pin_meta_ff <= {sample_clk, scb_clk, scb_ce, scb_di};
      pin_ff      <= pin_meta_ff;
      pin_prev_ff <= pin_ff;
    end
  end

  logic fs_rise;
  logic sck_rise;
  logic sck_fall;
  logic ce_rise;
  logic ce_fall;
  assign fs_rise  = pin_ff[3] & ~pin_prev_ff[3];
  assign sck_rise = pin_ff[2] & ~pin_prev_ff[2];
  assign sck_fall = ~pin_ff[2] & pin_prev_ff[2];
  assign ce_rise  = pin_ff[1] & ~pin_prev_ff[1];
  assign ce_fall  = ~pin_ff[1] & pin_prev_ff[1];

  // ==========================================================================
  // Reference tick: a phase accumulator yields 6144 ticks per 10000 clocks.
  logic [13:0] ref_acc_ff;
  logic [14:0] ref_sum;
  logic        ref_tick;
  assign ref_sum  = {1'b0, ref_acc_ff} + 15'(FSM_REF_KHZ);
  assign ref_tick = (ref_sum >= 15'(FSM_CLK_KHZ));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_acc_ff <= 14'h0000;
    end else if (ref_tick) begin
      ref_acc_ff <= 14'(ref_sum - 15'(FSM_CLK_KHZ));
    end else begin
      ref_acc_ff <= ref_sum[13:0];
    end
  end

  // ==========================================================================
  // Period measurement between sample clock rising edges.
  logic       fs_seen_ff;
  logic [7:0] per_cnt_ff;
  logic       per_ovf_ff;
  logic [7:0] rate_count_ff;
  logic [3:0] rate_code_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fs_seen_ff    <= 1'b0;
      per_cnt_ff    <= 8'h00;
      per_ovf_ff    <= 1'b0;
      rate_count_ff <= 8'h00;
      rate_code_ff  <= FSM_CODE_NONE;
    end else if (fs_rise) begin
      fs_seen_ff <= 1'b1;
      per_cnt_ff <= ref_tick ? 8'h01 : 8'h00;
      per_ovf_ff <= 1'b0;
      if (fs_seen_ff) begin
        rate_count_ff <= per_cnt_ff;
        rate_code_ff  <= fsm_code_of(per_cnt_ff, per_ovf_ff);
      end
    end else if (ref_tick) begin
      if (per_cnt_ff == FSM_COUNT_MAX) begin
        per_ovf_ff <= 1'b1;
      end else begin
        per_cnt_ff <= per_cnt_ff + 8'h01;
      end
    end
  end

  // ==========================================================================
  // Channel status capture.
  logic [FSM_CS_BITS-1:0] cs_shift_ff;
  logic [5:0]             cs_idx_ff;
  logic                   cs_run_ff;
  logic [FSM_CS_BITS-1:0] cs_cap_ff;
  logic [FSM_CS_BITS-1:0] nxt_cs;
  logic                   cs_done;
  logic                   chstat_sel_ff;

  always_comb begin
    nxt_cs = cs_shift_ff;
    nxt_cs[cs_idx_ff] = cs_bit;
  end
  assign cs_done = cs_bit_valid & cs_run_ff & (cs_idx_ff == 6'(FSM_CS_BITS - 1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_shift_ff <= '0;
      cs_idx_ff   <= 6'h00;
      cs_run_ff   <= 1'b0;
    end else if (cs_bit_valid) begin
      if (cs_block_start) begin
        cs_shift_ff    <= '0;
        cs_shift_ff[0] <= cs_bit;
        cs_idx_ff      <= 6'h01;
        cs_run_ff      <= 1'b1;
      end else if (cs_run_ff) begin
        cs_shift_ff <= nxt_cs;
        cs_idx_ff   <= cs_idx_ff + 6'h01;
        cs_run_ff   <= ~cs_done;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_cap_ff <= '0;
    end else if (cs_done && !chstat_sel_ff) begin
      cs_cap_ff <= nxt_cs;
    end
  end

  // ==========================================================================
  // Event flags; a new event wins over a read acknowledge in the same cycle.
  logic rate_evt;
  logic cs_evt;
  assign rate_evt = fs_rise & fs_seen_ff;
  assign cs_evt   = cs_done & ~chstat_sel_ff & (nxt_cs != cs_cap_ff);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rate_update_flag <= 1'b0;
    end else if (rate_evt) begin
      rate_update_flag <= 1'b1;
    end else if (flag_read_ack) begin
      rate_update_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chstat_renewed_flag <= 1'b0;
    end else if (cs_evt) begin
      chstat_renewed_flag <= 1'b1;
    end else if (flag_read_ack) begin
      chstat_renewed_flag <= 1'b0;
    end
  end

  // ==========================================================================
  // Serial control bus: address in while enable is low, data out while high.
  logic [7:0]             addr_ff;
  logic [FSM_CS_BITS-1:0] out_sr_ff;
  logic [GPIN_N-1:0]      gp_read;
  logic [FSM_CS_BITS-1:0] rate_word;
  logic                   hit_rate;
  logic                   hit_cs;

  assign gp_read  = gp_ff & gpin_is_input;
  assign hit_rate = (addr_ff == FSM_ADDR_RATE);
  assign hit_cs   = (addr_ff == FSM_ADDR_CHSTAT);

  always_comb begin
    rate_word = '0;
    rate_word[FSM_GPIN_LSB +: GPIN_N] = gp_read;
    rate_word[FSM_CODE_LSB +: 4]      = rate_code_ff;
    rate_word[FSM_COUNT_LSB +: 8]     = rate_count_ff;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_ff <= 8'h00;
    end else if (sck_rise && !pin_ff[1]) begin
      addr_ff <= {pin_ff[0], addr_ff[7:1]};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chstat_sel_ff <= 1'b0;
    end else if (ce_rise) begin
      chstat_sel_ff <= hit_cs;
    end else if (ce_fall) begin
      chstat_sel_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_sr_ff <= '0;
    end else if (ce_rise) begin
      if (hit_cs) begin
        out_sr_ff <= cs_cap_ff;
      end else if (hit_rate) begin
        out_sr_ff <= rate_word;
      end else begin
        out_sr_ff <= '0;
      end
    end else if (sck_fall && pin_ff[1]) begin
      out_sr_ff <= {1'b0, out_sr_ff[FSM_CS_BITS-1:1]};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scb_do_oe <= 1'b0;
    end else if (ce_rise) begin
      scb_do_oe <= hit_cs | hit_rate;
    end else if (ce_fall) begin
      scb_do_oe <= 1'b0;
    end
  end

  assign scb_do = out_sr_ff[0];

endmodule : fsm_readback

// ### fsm_pkg.sv
// What this block does
// - Address 0xEB selects rate and pin register
// - Bits 3..0 return general pin input levels
// - Bits 7..4 carry measured rate code
// - Bits 15..8 carry raw period count
// - Count reference cycles per sample period
// - Measurement valid only at 24 kHz up
// - Capture first 48 bits; address 0xEC
// - Channel status shifted out LSB first
// - Capture frozen while 0xEC is selected
// - Capture keeps standard channel status bit layout
// - Rate update flag set, cleared on read
// - Renewed flag set on change, cleared on read
package fsm_pkg;

  // ==========================================================================
  // Addresses and field layout.
  localparam logic [7:0] FSM_ADDR_RATE   = 8'hEB;
  localparam logic [7:0] FSM_ADDR_CHSTAT = 8'hEC;
  localparam int         FSM_GPIN_LSB    = 0;
  localparam int         FSM_CODE_LSB    = 4;
  localparam int         FSM_COUNT_LSB   = 8;
  localparam int         FSM_RATE_BITS   = 16;
  localparam int         FSM_CS_BITS     = 48;

  // ==========================================================================
  // Reference clock made from the system clock, in kHz.
  localparam int         FSM_CLK_KHZ     = 10000;
  localparam int         FSM_REF_KHZ     = 6144;
  localparam logic [7:0] FSM_COUNT_MAX   = 8'hFF;

  // ==========================================================================
  // Rate codes.
  localparam logic [3:0] FSM_CODE_NONE  = 4'h0;
  localparam logic [3:0] FSM_CODE_16K   = 4'h4;
  localparam logic [3:0] FSM_CODE_22K05 = 4'h5;
  localparam logic [3:0] FSM_CODE_24K   = 4'h6;
  localparam logic [3:0] FSM_CODE_32K   = 4'h7;
  localparam logic [3:0] FSM_CODE_44K1  = 4'h8;
  localparam logic [3:0] FSM_CODE_48K   = 4'h9;
  localparam logic [3:0] FSM_CODE_64K   = 4'hA;
  localparam logic [3:0] FSM_CODE_88K2  = 4'hB;
  localparam logic [3:0] FSM_CODE_96K   = 4'hC;
  localparam logic [3:0] FSM_CODE_128K  = 4'hD;
  localparam logic [3:0] FSM_CODE_176K4 = 4'hE;
  localparam logic [3:0] FSM_CODE_192K  = 4'hF;

  // Count windows follow the accepted frequency bands; an overflowed count
  // lies below 24 kHz and cannot be classified, so it reads as out of range.
  function automatic logic [3:0] fsm_code_of(input logic [7:0] cnt, input logic ovf);
    logic [3:0] c;
    c = FSM_CODE_NONE;
    if (!ovf) begin
      if (cnt >= 8'hF7) c = FSM_CODE_24K;
      else if (cnt >= 8'hB9 && cnt <= 8'hC7) c = FSM_CODE_32K;
      else if (cnt >= 8'h87 && cnt <= 8'h90) c = FSM_CODE_44K1;
      else if (cnt >= 8'h7C && cnt <= 8'h84) c = FSM_CODE_48K;
      else if (cnt >= 8'h5D && cnt <= 8'h63) c = FSM_CODE_64K;
      else if (cnt >= 8'h43 && cnt <= 8'h47) c = FSM_CODE_88K2;
      else if (cnt >= 8'h3E && cnt <= 8'h41) c = FSM_CODE_96K;
      else if (cnt >= 8'h2F && cnt <= 8'h31) c = FSM_CODE_128K;
      else if (cnt >= 8'h22 && cnt <= 8'h23) c = FSM_CODE_176K4;
      else if (cnt == 8'h20) c = FSM_CODE_192K;
    end
    return c;
  endfunction : fsm_code_of

endpackage : fsm_pkg

// ### fsm_readback_props.sv
module fsm_readback_props (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sample_clk,
  input wire logic cs_bit_valid,
  input wire logic flag_read_ack,
  input wire logic scb_clk,
  input wire logic scb_ce,
  input wire logic scb_do,
  input wire logic scb_do_oe,
  input wire logic rate_update_flag,
  input wire logic chstat_renewed_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [3:0] sclk_age_ff;
  logic [3:0] cs_age_ff;
  // ==========================================================================
  // Ages since the last sample edge and the last channel status bit.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) sclk_age_ff <= 4'hF;
    else if ($rose(sample_clk)) sclk_age_ff <= 4'h0;
    else if (sclk_age_ff != 4'hF) sclk_age_ff <= sclk_age_ff + 4'h1;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) cs_age_ff <= 4'hF;
    else if (cs_bit_valid) cs_age_ff <= 4'h0;
    else if (cs_age_ff != 4'hF) cs_age_ff <= cs_age_ff + 4'h1;
  end
  // ==========================================================================
  // Properties.
  a_oe_after_ce: assert property ($rose(scb_do_oe) |-> $past(scb_ce, 3)) else $error("oe rose without ce");
  a_oe_idle_low: assert property (!scb_ce [*8] |-> !scb_do_oe) else $error("oe high while ce low");
  a_do_shift_edge: assert property ($changed(scb_do) && scb_do_oe && $past(scb_do_oe) |-> !scb_clk && !$past(scb_clk, 2))
    else $error("data moved off a clock fall");
  a_rate_set_cause: assert property ($rose(rate_update_flag) |-> sclk_age_ff <= 4'h8) else $error("rate flag without edge");
  a_rate_ack_clear: assert property (flag_read_ack && sclk_age_ff > 4'h8 |=> !rate_update_flag) else $error("rate flag kept");
  a_rate_sticky: assert property ($fell(rate_update_flag) |-> $past(flag_read_ack)) else $error("rate flag lost");
  a_cs_set_cause: assert property ($rose(chstat_renewed_flag) |-> cs_age_ff <= 4'h4) else $error("renew flag without block");
  a_cs_ack_clear: assert property (flag_read_ack && cs_age_ff > 4'h4 |=> !chstat_renewed_flag) else $error("renew flag kept");
  a_cs_sticky: assert property ($fell(chstat_renewed_flag) |-> $past(flag_read_ack)) else $error("renew flag lost");
  c_read: cover property ($rose(scb_do_oe));
  c_rate: cover property ($rose(rate_update_flag));
  c_renew: cover property (flag_read_ack && chstat_renewed_flag);
endmodule : fsm_readback_props

// ### fsm_host_model.sv
module fsm_host_model (
  input  wire logic        clk,
  input  wire logic        scb_do,
  input  wire logic        scb_do_oe,
  output logic             scb_clk,
  output logic             scb_ce,
  output logic             scb_di,
  output logic [47:0]      rd_data,
  output logic [1:0]       rd_oe,
  output logic             rd_done
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scb_clk = 1'b0;
    scb_ce = 1'b0;
    scb_di = 1'b0;
    rd_data = '0;
    rd_oe = 2'b00;
    rd_done = 1'b0;
  end
  // ==========================================================================
  // Every pin level is held eight cycles, twice the sampler's need.
  task automatic hold();
    repeat (8) @(negedge clk);
  endtask : hold
  task automatic read(input logic [7:0] addr, input int nbits);
    hold();
    rd_data = '0;
    rd_oe = 2'b01;
    for (int i = 0; i < 8; i++) begin
      scb_di = addr[i];
      hold();
      scb_clk = 1'b1;
      hold();
      scb_clk = 1'b0;
      hold();
    end
    // A released data line shows the inverse of its last value.
    scb_di = ~scb_di;
    scb_ce = 1'b1;
    hold();
    for (int i = 0; i < nbits; i++) begin
      rd_data[i] = scb_do;
      rd_oe = {rd_oe[1] | scb_do_oe, rd_oe[0] & scb_do_oe};
      scb_clk = 1'b1;
      hold();
      scb_clk = 1'b0;
      hold();
    end
    scb_ce = 1'b0;
    rd_done = 1'b1;
    @(negedge clk);
    rd_done = 1'b0;
  endtask : read
endmodule : fsm_host_model

// ### fs_meter_status_readback_bench.sv
module fs_meter_status_readback_bench import fsm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, nrst, sample_clk, cs_bit, cs_bit_valid, cs_block_start, flag_read_ack;
  logic [3:0]  gpin_level, gpin_is_input;
  logic        scb_clk, scb_ce, scb_di, scb_do, scb_do_oe, rate_update_flag, chstat_renewed_flag, rd_done;
  logic [47:0] rd_data;
  logic [1:0]  rd_oe;
  logic [50:0] exp_q[$];
  int          err_total, check_count, sp;
  fsm_readback uut (.clk, .nrst, .gpin_level, .gpin_is_input, .sample_clk, .cs_bit, .cs_bit_valid, .cs_block_start,
    .flag_read_ack, .scb_clk, .scb_ce, .scb_di, .scb_do, .scb_do_oe, .rate_update_flag, .chstat_renewed_flag);
  fsm_host_model host (.clk, .scb_do, .scb_do_oe, .scb_clk, .scb_ce, .scb_di, .rd_data, .rd_oe, .rd_done);
  always #50 clk = ~clk;
  always begin
    if (sp == 0) @(negedge clk);
    else begin
      repeat (sp / 2) @(negedge clk);
      sample_clk = ~sample_clk;
    end
  end
  // ==========================================================================
  // Checking and closing.
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic report_and_stop();
    if (err_total == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  always @(posedge rd_done) begin
    logic [50:0] e;
    e = exp_q.pop_front();
    if (e[48] && rd_data[15:8] === e[15:8] + 8'h01) e[15:8] = e[15:8] + 8'h01;
    check("read data", rd_data, e[47:0]);
    check("read enable", {46'h0, rd_oe}, {46'h0, e[50:49]});
  end
  task automatic ack();
    @(negedge clk);
    flag_read_ack = 1'b1;
    @(negedge clk);
    flag_read_ack = 1'b0;
    repeat (2) @(negedge clk);
  endtask : ack
  task automatic send_block(input logic [47:0] v);
    for (int i = 0; i < 48; i++) begin
      @(negedge clk);
      {cs_bit, cs_bit_valid, cs_block_start} = {v[i], 1'b1, i == 0};
      @(negedge clk);
      {cs_bit_valid, cs_block_start} = 2'b00;
    end
    repeat (5) @(negedge clk);
  endtask : send_block
  initial begin
    repeat (50000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
  // ==========================================================================
  // Main sequence.
  initial begin
    int          per[6];
    logic [3:0]  codes[6];
    int          c;
    logic [47:0] v1;
    per = '{104, 226, 208, 312, 406, 500};
    codes = '{FSM_CODE_96K, FSM_CODE_44K1, FSM_CODE_48K, FSM_CODE_32K, FSM_CODE_24K, FSM_CODE_NONE};
    {clk, nrst, sample_clk, cs_bit, cs_bit_valid, cs_block_start, flag_read_ack} = '0;
    {gpin_level, gpin_is_input, err_total, check_count, sp} = '0;
    void'($urandom(32'h9419));
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    repeat (5) @(negedge clk);
    for (int i = 0; i < 6; i++) begin
      sp = per[i];
      {gpin_level, gpin_is_input} = 8'($urandom());
      repeat (3 * sp + 20) @(negedge clk);
      check("rate flag", {47'h0, rate_update_flag}, 48'h1);
      c = sp * 384 / 625;
      exp_q.push_back({2'b11, c < 255, 32'h0, c > 255 ? 8'hFF : 8'(c), codes[i], gpin_level & gpin_is_input});
      host.read(FSM_ADDR_RATE, 16);
    end
    sp = 0;
    repeat (600) @(negedge clk);
    ack();
    check("rate flag", {47'h0, rate_update_flag}, 48'h0);
    v1 = 48'({$urandom(), $urandom()});
    send_block(v1);
    check("renew flag", {47'h0, chstat_renewed_flag}, 48'h1);
    ack();
    check("renew flag", {47'h0, chstat_renewed_flag}, 48'h0);
    repeat (3) exp_q.push_back({3'b110, v1});
    host.read(FSM_ADDR_CHSTAT, 48);
    fork
      host.read(FSM_ADDR_CHSTAT, 48);
      begin
        repeat (400) @(negedge clk);
        send_block(~v1);
      end
    join
    check("renew flag", {47'h0, chstat_renewed_flag}, 48'h0);
    host.read(FSM_ADDR_CHSTAT, 48);
    send_block(~v1);
    check("renew flag", {47'h0, chstat_renewed_flag}, 48'h1);
    exp_q.push_back({3'b110, ~v1});
    host.read(FSM_ADDR_CHSTAT, 48);
    exp_q.push_back(51'h0);
    host.read(8'hED, 16);
    repeat (20) @(negedge clk);
    report_and_stop();
  end
endmodule : fs_meter_status_readback_bench
bind fsm_readback fsm_readback_props u_props (.clk, .nrst, .sample_clk, .cs_bit_valid, .flag_read_ack, .scb_clk,
  .scb_ce, .scb_do, .scb_do_oe, .rate_update_flag, .chstat_renewed_flag);
